// ### hdl/ccd_cpu_clock_divider.sv
// CPU clock divider and ratio select, with an APB register slave.
// Assumes oscillator ticks arrive as one-cycle enables synchronous to clk,
// and that the crystal/fast-oscillator option strap is stable around reset.
`timescale 1ns/100ps
`default_nettype none
`include "ccd_defs.svh"

module ccd_cpu_clock_divider
(
   input wire logic clk,
   input wire logic resetn,
   input wire ccd_pkg::ccd_apb_req_type apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic crystal_osc_clock,
   input wire logic fast_osc_tick,
   input wire logic slow_internal_osc_clock,
   input wire logic option_use_crystal,
   output logic cpu_clk_en,
   output logic instr_slot_en,
   output logic cpu_on_high_speed
);

   // ****************************************
   // Helpers
   // ****************************************
   // Codes above divide-by-16 are forbidden; they fall back to the slowest rate.
   function automatic logic [3:0] ratio_limit(input logic [2:0] code);
      case (code)
         `CCD_CODE_DIV1: ratio_limit = `CCD_LIM_DIV1;
         `CCD_CODE_DIV2: ratio_limit = `CCD_LIM_DIV2;
         `CCD_CODE_DIV4: ratio_limit = `CCD_LIM_DIV4;
         `CCD_CODE_DIV8: ratio_limit = `CCD_LIM_DIV8;
         default: ratio_limit = `CCD_LIM_DIV16;
      endcase
   endfunction

   // Applied source is a two-value enum; one place decides what high means
   function automatic logic src_is_high(input ccd_pkg::ccd_src_type src);
      src_is_high = (src == ccd_pkg::CCD_SRC_HIGH);
   endfunction

   // Status layout kept in one place so readback and field macros agree
   function automatic logic [7:0] status_pack(input logic src_high, input logic [2:0] ratio, input logic xtal);
      status_pack = 8'h00;
      status_pack[`CCD_STAT_SRC_BIT] = src_high;
      status_pack[`CCD_STAT_RATIO_MSB:`CCD_STAT_RATIO_LSB] = ratio;
      status_pack[`CCD_STAT_XTAL_BIT] = xtal;
   endfunction

   // ****************************************
   // Register bus decode
   // ****************************************
   logic [7:0] cpu_clock_ratio_ctrl_r;
   logic [7:0] main_clock_mode_reg_r;
   logic crystal_sel_r;
   logic strap_taken_r;
   logic [2:0] ratio_applied_r;
   ccd_pkg::ccd_src_type src_applied_r;
   logic [3:0] count_r;
   logic half_r;
   logic [31:0] prdata_r;

   wire setup_phase = apb_req.psel && !apb_req.penable;
   wire access_phase = apb_req.psel && apb_req.penable;
   wire hit_ratio = apb_req.paddr == `CCD_RATIO_OFFSET;
   wire hit_mode = apb_req.paddr == `CCD_MODE_OFFSET;
   wire hit_status = apb_req.paddr == `CCD_STATUS_OFFSET;
   wire hit_any = hit_ratio || hit_mode || hit_status;
   wire bad_write = hit_status && apb_req.pwrite;
   wire wr_lane0 = access_phase && apb_req.pwrite && apb_req.pstrb[0];
   wire wr_ratio = wr_lane0 && hit_ratio;
   wire wr_mode = wr_lane0 && hit_mode;
   wire main_source_sel = main_clock_mode_reg_r[`CCD_SRC_BIT];

   // ****************************************
   // Read mux and response
   // ****************************************
   // Unmapped reads return zero so software probing is harmless
   wire [7:0] status_byte = status_pack(src_is_high(src_applied_r), ratio_applied_r, crystal_sel_r);
   wire [31:0] rd_mux = hit_ratio ? {24'h000000, cpu_clock_ratio_ctrl_r} :
                        hit_mode ? {24'h000000, main_clock_mode_reg_r} :
                        hit_status ? {24'h000000, status_byte} : 32'h00000000;

   // Zero-wait slave: answer in the first access cycle
   assign pready = access_phase;
   assign pslverr = access_phase && (!hit_any || bad_write);
   assign prdata = prdata_r;

   // ****************************************
   // Source and divider
   // ****************************************
   wire hs_tick = crystal_sel_r ? crystal_osc_clock : fast_osc_tick;
   wire main_tick = src_is_high(src_applied_r) ? hs_tick : slow_internal_osc_clock;
   wire [3:0] limit = ratio_limit(ratio_applied_r);
   wire cpu_tick = main_tick && (count_r == limit);
   wire [3:0] count_inc = count_r + 4'h1;
   wire [2:0] ratio_req = cpu_clock_ratio_ctrl_r[`CCD_RATIO_MSB:`CCD_RATIO_LSB];
   // Source bit: 1 picks high-speed, 0 the slow oscillator
   wire ccd_pkg::ccd_src_type src_req = main_source_sel ? ccd_pkg::CCD_SRC_HIGH : ccd_pkg::CCD_SRC_SLOW;

   // ****************************************
   // Outputs
   // ****************************************
   // Ticks stay combinational so the CPU and divider see the same edge
   assign cpu_clk_en = cpu_tick;
   assign instr_slot_en = cpu_tick && (half_r == `CCD_CPU_TICKS_PER_INSTR);
   assign cpu_on_high_speed = src_is_high(src_applied_r);

   // ****************************************
   // Software register next state
   // ****************************************
   logic [7:0] cpu_clock_ratio_ctrl_nxt;
   logic [7:0] main_clock_mode_reg_nxt;
   logic [31:0] prdata_nxt;
   logic crystal_sel_nxt;
   logic strap_taken_nxt;
   logic [3:0] count_nxt;
   logic half_nxt;
   logic [2:0] ratio_applied_nxt;
   ccd_pkg::ccd_src_type src_applied_nxt;

   // Whole byte is stored, so a read-modify-write bit operation keeps the other bits
   always_comb
   begin
      cpu_clock_ratio_ctrl_nxt = cpu_clock_ratio_ctrl_r;
      if (wr_ratio)
      begin
         cpu_clock_ratio_ctrl_nxt = apb_req.pwdata[7:0];
      end
   end

   // Only the source bit is kept; the other bits read back as zero
   always_comb
   begin
      main_clock_mode_reg_nxt = main_clock_mode_reg_r;
      if (wr_mode)
      begin
         main_clock_mode_reg_nxt = {7'h00, apb_req.pwdata[`CCD_SRC_BIT]};
      end
   end

   // ****************************************
   // Read data next state
   // ****************************************
   // Read data is taken in setup so it already stands in the access cycle
   always_comb
   begin
      prdata_nxt = prdata_r;
      if (setup_phase && !apb_req.pwrite)
      begin
         prdata_nxt = rd_mux;
      end
   end

   // ****************************************
   // Strap capture next state
   // ****************************************
   // Strap is caught once after reset release; a live pin could glitch the source
   // Limitation: a new strap level needs a reset to take effect
   always_comb
   begin
      crystal_sel_nxt = crystal_sel_r;
      strap_taken_nxt = strap_taken_r;
      if (!strap_taken_r)
      begin
         crystal_sel_nxt = option_use_crystal;
         strap_taken_nxt = 1'b1;
      end
   end

   // ****************************************
   // Divider next state
   // ****************************************
   // Boundary: adopt pending settings so no CPU period is cut short
   // Trade-off: a new setting waits up to one old CPU period
   // Count never passes the divide-by-16 limit, so four bits suffice
   always_comb
   begin
      count_nxt = count_r;
      half_nxt = half_r;
      ratio_applied_nxt = ratio_applied_r;
      src_applied_nxt = src_applied_r;
      if (cpu_tick)
      begin
         count_nxt = 4'h0;
         half_nxt = ~half_r;
         ratio_applied_nxt = ratio_req;
         src_applied_nxt = src_req;
      end
      else if (main_tick)
      begin
         count_nxt = count_inc;
      end
   end

   // ****************************************
   // Software registers
   // ****************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cpu_clock_ratio_ctrl_r <= `CCD_RATIO_RESET;
      end
      else
      begin
         cpu_clock_ratio_ctrl_r <= cpu_clock_ratio_ctrl_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         main_clock_mode_reg_r <= `CCD_MODE_RESET;
      end
      else
      begin
         main_clock_mode_reg_r <= main_clock_mode_reg_nxt;
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata_r <= 32'h00000000;
      end
      else
      begin
         prdata_r <= prdata_nxt;
      end
   end

   // ****************************************
   // Strap
   // ****************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         crystal_sel_r <= 1'b0;
         strap_taken_r <= 1'b0;
      end
      else
      begin
         crystal_sel_r <= crystal_sel_nxt;
         strap_taken_r <= strap_taken_nxt;
      end
   end

   // ****************************************
   // Divider
   // ****************************************
   // Count restarts and phase flips together at every CPU tick
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         count_r <= 4'h0;
         half_r <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         half_r <= half_nxt;
      end
   end

   // Applied settings reset to slow and undivided, matching the register reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ratio_applied_r <= `CCD_CODE_DIV1;
         src_applied_r <= ccd_pkg::CCD_SRC_SLOW;
      end
      else
      begin
         ratio_applied_r <= ratio_applied_nxt;
         src_applied_r <= src_applied_nxt;
      end
   end

endmodule
`default_nettype wire

// ### hdl/ccd_defs.svh
// Register offsets, field positions, reset values and counts for the CPU clock divider.
// Assumes inclusion by bare name from the design files.
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define CCD_RATIO_OFFSET 12'h000
`define CCD_MODE_OFFSET 12'h004
`define CCD_STATUS_OFFSET 12'h008

// ****************************************
// Fields and reset values
// ****************************************
`define CCD_RATIO_RESET 8'h00
`define CCD_MODE_RESET 8'h00
`define CCD_RATIO_LSB 0
`define CCD_RATIO_MSB 2
`define CCD_SRC_BIT 0
`define CCD_STAT_SRC_BIT 0
`define CCD_STAT_RATIO_LSB 1
`define CCD_STAT_RATIO_MSB 3
`define CCD_STAT_XTAL_BIT 4

// ****************************************
// Ratio codes and divider limits
// ****************************************
`define CCD_CODE_DIV1 3'h0
`define CCD_CODE_DIV2 3'h1
`define CCD_CODE_DIV4 3'h2
`define CCD_CODE_DIV8 3'h3
`define CCD_CODE_DIV16 3'h4
`define CCD_LIM_DIV1 4'h0
`define CCD_LIM_DIV2 4'h1
`define CCD_LIM_DIV4 4'h3
`define CCD_LIM_DIV8 4'h7
`define CCD_LIM_DIV16 4'hf
`define CCD_CPU_TICKS_PER_INSTR 1'b1

`endif

// ### hdl/ccd_pkg.sv
// Types shared by the CPU clock divider and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package ccd_pkg;

   typedef enum logic {CCD_SRC_SLOW, CCD_SRC_HIGH} ccd_src_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } ccd_apb_req_type;

endpackage

// ### dv/ccd_cpu_clock_divider_sva.sv
// Port checker for the CPU clock divider.
// Assumes tick inputs are one-cycle enables on clk.
`timescale 1ns/100ps
`default_nettype none
// ****
// Checker
// ****
module ccd_cpu_clock_divider_chk
(
   input wire logic clk,
   input wire logic resetn,
   input wire ccd_pkg::ccd_apb_req_type apb_req,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic crystal_osc_clock,
   input wire logic fast_osc_tick,
   input wire logic slow_internal_osc_clock,
   input wire logic option_use_crystal,
   input wire logic cpu_clk_en,
   input wire logic instr_slot_en,
   input wire logic cpu_on_high_speed
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Parity of CPU ticks, slot due on odd ones
   logic par_r;
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         par_r <= 1'b0;
      else if (cpu_clk_en)
         par_r <= ~par_r;
   AST_ACCESS: assert property (apb_req.psel && apb_req.penable |-> pready) else $error("access unanswered");
   AST_ERR: assert property (pslverr |-> apb_req.psel && apb_req.penable) else $error("stray error");
   AST_SLOT: assert property (instr_slot_en == (cpu_clk_en && par_r)) else $error("slot not every 2nd tick");
   AST_SLOW: assert property (cpu_clk_en && !cpu_on_high_speed |-> slow_internal_osc_clock)
      else $error("tick not from slow osc");
   AST_HIGH: assert property (cpu_clk_en && cpu_on_high_speed |->
      (option_use_crystal ? crystal_osc_clock : fast_osc_tick)) else $error("wrong fast source");
   AST_SWITCH: assert property ($changed(cpu_on_high_speed) |-> $past(cpu_clk_en)) else $error("switch off tick");
   AST_RST: assert property (disable iff (1'b0) !resetn |-> !cpu_on_high_speed && !instr_slot_en)
      else $error("reset state wrong");
endmodule
bind ccd_cpu_clock_divider ccd_cpu_clock_divider_chk ccd_cpu_clock_divider_chk_i(.clk(clk), .resetn(resetn),
   .apb_req(apb_req), .pready(pready), .pslverr(pslverr), .crystal_osc_clock(crystal_osc_clock),
   .fast_osc_tick(fast_osc_tick), .slow_internal_osc_clock(slow_internal_osc_clock),
   .option_use_crystal(option_use_crystal), .cpu_clk_en(cpu_clk_en), .instr_slot_en(instr_slot_en),
   .cpu_on_high_speed(cpu_on_high_speed));
`default_nettype wire

// ### dv/ccd_cpu_clock_divider_tb.sv
// Bench for the CPU clock divider: APB register access and tick spacing.
// Assumes an APB slave that answers in bounded time; the option strap is driven here.
`timescale 1ns/100ps
`default_nettype none
`include "ccd_defs.svh"
// ****
// Bench
// ****
module ccd_cpu_clock_divider_tb;
   logic clk = 1'b0;
   logic resetn = 1'b1;
   logic strap = 1'b1;
   ccd_pkg::ccd_apb_req_type req = '0;
   logic xt = 1'b0, ft = 1'b0, st = 1'b0, e;
   logic [3:0] tc = 4'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, cpu_clk_en, instr_slot_en, cpu_on_high_speed;
   int n_mismatch = 0, checks = 0, n;
   always #50 clk = ~clk;
   // Crystal every 2nd cycle, slow osc every 4th
   always @(posedge clk)
   begin
      tc <= tc + 4'h1;
      xt <= ~xt;
      ft <= tc[0];
      st <= (tc[1:0] == 2'h0);
   end
   ccd_cpu_clock_divider ccd_cpu_clock_divider_i(.clk(clk), .resetn(resetn), .apb_req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .crystal_osc_clock(xt), .fast_osc_tick(ft), .slow_internal_osc_clock(st),
      .option_use_crystal(strap), .cpu_clk_en(cpu_clk_en), .instr_slot_en(instr_slot_en),
      .cpu_on_high_speed(cpu_on_high_speed));
   task give_verdict;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d, 4'hf};
      @(posedge clk);
      req.penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      req <= '0;
      if (k >= 20)
      begin
         n_mismatch++;
         give_verdict;
      end
   endtask
   // Returns cycles since the previous CPU tick
   task tick;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (cpu_clk_en !== 1'b1 && n < 100);
      if (n >= 100)
      begin
         n_mismatch++;
         give_verdict;
      end
   endtask
   initial
   begin
      resetn <= 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, `CCD_RATIO_OFFSET, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, `CCD_STATUS_OFFSET, 32'h0);
      chk(q, 32'h10);
      apb(1'b0, 12'h00c, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      tick;
      tick;
      chk(32'(n), 32'h4);
      $display("reset test done");
      apb(1'b1, `CCD_MODE_OFFSET, 32'h1);
      tick;
      tick;
      chk({31'h0, cpu_on_high_speed}, 32'h1);
      for (int c = 0; c < 5; c++)
      begin
         apb(1'b1, `CCD_RATIO_OFFSET, 32'(c));
         apb(1'b0, `CCD_RATIO_OFFSET, 32'h0);
         chk(q, 32'(c));
         tick;
         tick;
         tick;
         chk(32'(n), 32'(2 << c));
      end
      $display("ratio test done");
      apb(1'b1, `CCD_RATIO_OFFSET, 32'h1);
      apb(1'b1, `CCD_MODE_OFFSET, 32'h0);
      tick;
      tick;
      tick;
      chk(32'(n), 32'h8);
      $display("slow switch test done");
      strap <= 1'b0;
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, `CCD_STATUS_OFFSET, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, `CCD_RATIO_OFFSET, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, `CCD_MODE_OFFSET, 32'h1);
      tick;
      tick;
      tick;
      chk(32'(n), 32'h2);
      $display("strap reset test done");
      give_verdict;
   end
endmodule
`default_nettype wire
